// [core/amp_prot_ctrl.sv]
// Protection, fault reporting and start-up sequencing of a class-D power stage
// Operation
// RULE1: Reset low ramps outputs down, idle state
// RULE2: Host drives reset, never leaves floating
// RULE3: Host holds reset low before power
// RULE4: Short detected disables outputs immediately
// RULE5: Short latched until reset low-high cycle
// RULE6: Fault output low on short detect
// RULE7: Fault stays low until reset cycled
// RULE8: Over-temperature enters shutdown, outputs off
// RULE9: Thermal shutdown self-recovers after cooling
// RULE10: Thermal shutdown never asserts fault output
// RULE11: Warning output low at warning temperature
// RULE12: Warning clears by itself, no reset
// RULE13: Single-ended start-up lasts half second
// RULE14: Modulator keeps PWM switching, 50% mute
// RULE15: Modulator keeps switching for turn-off time
// RULE16: Synchronise asynchronous inputs before fault logic
`timescale 1ns/100ps
module amp_prot_ctrl
  import amp_prot_pkg::*;
#(
  parameter longint unsigned SE_STARTUP_CNT = amp_prot_pkg::SE_STARTUP_CYCLES,
  parameter longint unsigned BTL_STARTUP_CNT = amp_prot_pkg::BTL_STARTUP_CYCLES
) (
  // Clock and system reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Host side: stage shutdown pin and mode strap
  input wire logic stage_reset_n_i,
  input wire logic output_config_select_i,
  // Analog detectors
  input wire amp_prot_pkg::detect_t detect_i,
  // Output stage control
  output logic drive_enable_o,
  output logic ramp_down_o,
  output logic low_power_o,
  // Host flags: fault and warning active low open-drain style, status word active high
  output logic fault_n_o,
  output logic temp_warning_n_o,
  output amp_prot_pkg::stage_status_t status_o
);

  import amp_prot_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN
  } state_t;

  // Mode strap is a pin too, so it rides the same chain as the other levels
  localparam int unsigned SYNC_W = NUM_OUT + 4;

  logic [SYNC_W-1:0] sync_w;
  logic [NUM_OUT-1:0] short_s;
  logic over_temp_s;
  logic warn_temp_s;
  logic stage_run_s;
  logic cfg_se_s;

  input_sync #(
    .WIDTH(SYNC_W),
    .INIT('0)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({detect_i.short_det, detect_i.over_temp, detect_i.warn_temp,
              stage_reset_n_i, output_config_select_i}),
    .sync_o(sync_w)
  ); // RULE16

  assign short_s = sync_w[SYNC_W-1 -: NUM_OUT];
  assign over_temp_s = sync_w[3];
  assign warn_temp_s = sync_w[2];
  assign stage_run_s = sync_w[1];
  assign cfg_se_s = sync_w[0];

  state_t state_r;
  state_t state_nxt;
  logic short_latch_r;
  logic mode_se_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic drive_en_r;
  logic fault_n_r;
  logic warn_n_r;

  // Short seen after the synchroniser and agreement filter; short_raw covers the async path
  wire short_now = |short_s;
  wire short_raw = |detect_i.short_det;
  wire start_done = (cnt_r == '0);
  wire [CNT_W-1:0] start_load = mode_se_r ? CNT_W'(SE_STARTUP_CNT) : CNT_W'(BTL_STARTUP_CNT);
  wire hold_off = !stage_run_s || short_latch_r || over_temp_s;

  // Latch clears only while the stage reset is low; a live short wins
  wire short_latch_nxt = short_now ? 1'b1 : (stage_run_s ? short_latch_r : 1'b0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (!hold_off) begin
          state_nxt = ST_START;
          cnt_nxt = start_load;
        end
      end
      ST_START: begin
        if (hold_off) begin
          state_nxt = ST_IDLE;
        end else if (start_done) begin
          state_nxt = ST_RUN; // RULE13
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (hold_off) begin
          state_nxt = ST_IDLE; // RULE1 RULE8
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Mode strap sampled only while the stage is held in reset
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mode_se_r <= 1'b0;
    end else if (!stage_run_s) begin
      mode_se_r <= cfg_se_s;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      short_latch_r <= 1'b0;
      drive_en_r <= 1'b0;
      fault_n_r <= 1'b1;
      warn_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      short_latch_r <= short_latch_nxt; // RULE5
      drive_en_r <= (state_nxt == ST_RUN) && !short_now;
      fault_n_r <= !short_latch_nxt; // RULE6 RULE7 RULE10
      warn_n_r <= !warn_temp_s; // RULE11 RULE12
    end
  end

  // Raw short term gates drive at once, before synchronisation delay
  assign drive_enable_o = drive_en_r && !short_raw; // RULE4
  assign ramp_down_o = !stage_run_s; // RULE1
  assign low_power_o = !stage_run_s && (state_r == ST_IDLE);
  assign fault_n_o = fault_n_r;
  assign temp_warning_n_o = warn_n_r;
  // Thermal shutdown recovers with the detector; hysteresis lives in the comparator
  assign status_o = '{outputs_enabled: drive_en_r,
                      short_latched: short_latch_r,
                      thermal_shutdown: over_temp_s, // RULE9
                      starting: (state_r == ST_START)};

endmodule : amp_prot_ctrl

// [core/amp_prot_pkg.sv]
// Shared constants and carrier types for the power stage protection control
package amp_prot_pkg;

  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Start-up time per microfarad of bias capacitance, single-ended mode
  localparam int unsigned SE_STARTUP_MS_PER_UF = 500;
  localparam int unsigned BYP_CAP_UF = 1;
  localparam int unsigned SE_STARTUP_MS = SE_STARTUP_MS_PER_UF * BYP_CAP_UF;
  localparam longint unsigned SE_STARTUP_CYCLES =
    longint'(SE_STARTUP_MS) * longint'(CLK_FREQ_HZ) / 64'd1000;

  // Bridged start-up is fast; a short settling time, not documented in detail
  localparam int unsigned BTL_STARTUP_US = 10;
  localparam longint unsigned BTL_STARTUP_CYCLES =
    longint'(BTL_STARTUP_US) * longint'(CLK_FREQ_HZ) / 64'd1_000_000;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned NUM_OUT = 4;

  // Fault detector inputs, all asynchronous comparator levels
  typedef struct packed {
    logic [NUM_OUT-1:0] short_det;
    logic over_temp;
    logic warn_temp;
  } detect_t;

  // Stage status as seen by the host
  typedef struct packed {
    logic outputs_enabled;
    logic short_latched;
    logic thermal_shutdown;
    logic starting;
  } stage_status_t;

endpackage : amp_prot_pkg

// [core/input_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/100ps
module input_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] val_r;
  wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    s1_r <= async_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          val_r[g] <= INIT[g];
        end else if (agree[g]) begin
          val_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = val_r;

endmodule : input_sync

// [test/amp_prot_host.sv]
// Host model driving the stage shutdown pin and mode strap
`timescale 1ns/100ps
module amp_prot_host (
  // Clock and commands
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic se_i,
  // Pins toward the stage
  output logic stage_reset_n_o,
  output logic output_config_select_o,
  output logic pwm_o
);
  // Modulator carrier never stops, 50% duty doubles as mute
  initial pwm_o = 1'b0;
  always @(posedge sys_clk_i) pwm_o <= ~pwm_o;
  initial begin
    stage_reset_n_o = 1'b0;
    output_config_select_o = 1'b0;
  end
  // Strap moves only while the stage sits in shutdown
  always @(posedge sys_clk_i) begin
    if (!stage_reset_n_o) begin
      output_config_select_o <= se_i;
    end
    stage_reset_n_o <= run_i;
  end
endmodule : amp_prot_host

// [test/amp_prot_ctrl_sva.sv]
// Assertion checker for the stage protection control
`timescale 1ns/100ps
module amp_prot_ctrl_sva
  import amp_prot_pkg::*;
#(
  parameter longint unsigned SE_STARTUP_CNT = 100
) (
  // Clock and inputs
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic stage_reset_n_i,
  input wire logic output_config_select_i,
  input wire amp_prot_pkg::detect_t detect_i,
  // Outputs
  input wire logic drive_enable_o,
  input wire logic ramp_down_o,
  input wire logic fault_n_o,
  input wire logic temp_warning_n_o,
  input wire logic low_power_o,
  input wire amp_prot_pkg::stage_status_t status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  short_off_a: assert property (|detect_i.short_det |-> !drive_enable_o)
    else $error("drive on during short");
  fault_hold_a: assert property (!fault_n_o && !ramp_down_o |=> !fault_n_o)
    else $error("fault cleared without stage reset");
  fault_cause_a: assert property ($fell(fault_n_o) |-> $past(|detect_i.short_det, 3))
    else $error("fault without short");
  otemp_off_a: assert property (detect_i.over_temp [*6] |=> !drive_enable_o)
    else $error("drive on when hot");
  warn_on_a: assert property (detect_i.warn_temp [*6] |=> !temp_warning_n_o)
    else $error("warning missing");
  warn_off_a: assert property (!detect_i.warn_temp [*6] |=> temp_warning_n_o)
    else $error("warning stuck");
  idle_ramp_a: assert property (!stage_reset_n_i [*6] |=> ramp_down_o && !drive_enable_o)
    else $error("not idle in shutdown");
  start_wait_a: assert property ($rose(drive_enable_o) && output_config_select_i
    |-> $past(!ramp_down_o, SE_STARTUP_CNT))
    else $error("start too early");
  low_idle_a: assert property (low_power_o |-> ramp_down_o && !drive_enable_o)
    else $error("low power while driving");
  status_fault_a: assert property (status_o.short_latched == !fault_n_o)
    else $error("status and fault disagree");
  status_drive_a: assert property (drive_enable_o |-> status_o.outputs_enabled)
    else $error("status misses drive");
  status_hot_a: assert property (detect_i.over_temp [*6] |=> status_o.thermal_shutdown)
    else $error("status misses thermal shutdown");
endmodule : amp_prot_ctrl_sva
bind amp_prot_ctrl amp_prot_ctrl_sva #(.SE_STARTUP_CNT(SE_STARTUP_CNT)) sva_inst (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .stage_reset_n_i(stage_reset_n_i),
  .output_config_select_i(output_config_select_i), .detect_i(detect_i),
  .drive_enable_o(drive_enable_o), .ramp_down_o(ramp_down_o), .fault_n_o(fault_n_o),
  .temp_warning_n_o(temp_warning_n_o), .low_power_o(low_power_o), .status_o(status_o));

// [test/amp_prot_ctrl_tb.sv]
// Self-checking bench for the stage protection control
`timescale 1ns/100ps
module amp_prot_ctrl_tb;
  import amp_prot_pkg::*;
  logic sys_clk_i = 0, reset_n_i = 0, run = 0, se = 0, obs = 0;
  logic stage_rst_n, cfg, drive_en, fault_n, warn_n;
  detect_t det = '0;
  logic [31:0] seed = 32'hb571;
  logic [2:0] exp_q[$];
  int error_cnt = 0, compares = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  amp_prot_host amp_prot_host_inst (.sys_clk_i(sys_clk_i), .run_i(run), .se_i(se),
    .stage_reset_n_o(stage_rst_n), .output_config_select_o(cfg), .pwm_o());
  amp_prot_ctrl #(.SE_STARTUP_CNT(100), .BTL_STARTUP_CNT(10)) amp_prot_ctrl_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .stage_reset_n_i(stage_rst_n),
    .output_config_select_i(cfg), .detect_i(det), .drive_enable_o(drive_en),
    .ramp_down_o(), .low_power_o(), .fault_n_o(fault_n), .temp_warning_n_o(warn_n),
    .status_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask : cyc
  // Expected {drive, fault_n, warn_n}
  task automatic expect_out(input logic [2:0] e);
    exp_q.push_back(e);
    #1 obs = ~obs;
    // Let the watcher sample before the next stimulus lands
    #0.5;
  endtask : expect_out
  always @(obs) begin
    logic [2:0] e;
    e = exp_q.pop_front();
    compares++;
    if ({drive_en, fault_n, warn_n} !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, {drive_en, fault_n, warn_n});
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Bounded wait; running out counts as a mismatch
  task automatic wait_drive();
    int n;
    n = 0;
    while (drive_en !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
    end
    if (drive_en !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_drive
  initial begin
    cyc(10);
    reset_n_i = 1;
    expect_out(3'b011);
    for (int m = 0; m < 2; m++) begin
      se = m[0];
      cyc(2);
      run = 1;
      wait_drive();
      expect_out(3'b111);
      seed = xs(seed);
      det.short_det = 4'h1 << seed[1:0];
      expect_out(3'b011);
      cyc(8);
      expect_out(3'b001);
      det.short_det = '0;
      cyc(20);
      expect_out(3'b001);
      run = 0;
      cyc(10);
      expect_out(3'b011);
    end
    run = 1;
    wait_drive();
    cyc(120);
    det.over_temp = 1;
    cyc(8);
    expect_out(3'b011);
    det.over_temp = 0;
    wait_drive();
    expect_out(3'b111);
    repeat (16) begin
      seed = xs(seed);
      det.warn_temp = seed[0];
      cyc(8);
      expect_out({2'b11, ~seed[0]});
    end
    finish_test();
  end
endmodule : amp_prot_ctrl_tb
